//--- hsc_line_sync.sv
// line sync processing: polarity, coast gating and regenerated sync
`timescale 1ns/1ns
// Overview of operation
// [RL1] sample phase steps across one clock period in 32 equal steps
// [RL2] incoming line sync is the reference for the sampling clock
// [RL3] input sync polarity is found so the output polarity is known
// [RL4] control bit 4 of register 04 picks output sync polarity
// [RL5] regenerated sync lines up with the delayed pixel data outputs
// [RL6] pulse width in pixel clocks comes from register 07
// [RL7] asynchronous coast blocks the clock reference, clock keeps running
// [RL8] coast comes from the coast pin or from internal sync logic
// [RL9] outside source should leave coast idle with a dedicated sync wire
// [RL10] a control bit sets the active level of the coast pin
// [RL11] without auto detect, software sets sync and coast polarity bits
// [RL12] pulse starts with the aligned leading edge, lasts programmed count
module hsc_line_sync #(
	parameter int DATA_LAT = 3,   // pixel pipeline depth, at least 2
	parameter int PIX_W    = 24
) (
	// clock and reset
	input  wire logic             clk_sys,
	input  wire logic             resetn,
	// register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [7:0]       reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic      [7:0]       reg_rdata,
	// sync and coast pins
	input  wire logic             line_sync_in,
	input  wire logic             coast_in,
	// sampled pixel data
	input  wire logic [PIX_W-1:0] pix_in,
	output logic      [PIX_W-1:0] pix_out,
	// clock generator side
	output logic                  pll_ref_out,
	output logic                  pll_hold,
	output logic [hsc_pkg::PHASE_W-1:0] sample_phase,
	// regenerated sync
	output logic                  regen_line_sync_out
);
	localparam int CW = hsc_pkg::CNT_W;

	typedef struct packed {
		logic [7:0]                    ctrl;
		logic [7:0]                    width;
		logic [hsc_pkg::PHASE_W-1:0]   phase;
		logic [7:0]                    rdata;
		logic                          hs_prev;
		logic                          hsn_prev;
		logic                          det_pol;
		logic [CW-1:0]                 hi_cnt;
		logic [CW-1:0]                 lo_cnt;
		logic [CW-1:0]                 line_cnt;
		logic [CW-1:0]                 period;
		logic                          period_ok;
		logic                          ref_out;
		logic                          hold;
		logic [DATA_LAT-1:0]           lead_pipe;
		logic [DATA_LAT-1:0][PIX_W-1:0] pix_pipe;
		logic [PIX_W-1:0]              pix_q;
		logic [7:0]                    wcnt;
		logic                          sync_out;
	} hsc_state_t;

	hsc_state_t s_q;
	hsc_state_t s_d;
	logic [1:0] pins_s;
	logic       hs_s;
	logic       coast_s;
	logic       pol_high;
	logic       hsn;
	logic       lead;
	logic       coast_ext;
	logic       coast_int;
	logic       coast_act;
	logic [CW:0] coast_lim;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	hsc_sync2 #(
		.W (2)
	) u_sync (
		.clk_sys (clk_sys),
		.resetn  (resetn),
		.d       ({coast_in, line_sync_in}),
		.q       (pins_s)
	);
	assign hs_s    = pins_s[0];
	assign coast_s = pins_s[1];

	// ------------------------------------------------------------
	// polarity, leading edge and coast decode
	// ------------------------------------------------------------
	// manual bit used when detection is off, software keeps it right
	always_comb begin
		pol_high  = s_q.ctrl[hsc_pkg::AUTO_POL_BIT] ? s_q.det_pol
		          : s_q.ctrl[hsc_pkg::HS_POL_BIT];         // RL3
		hsn       = pol_high ? hs_s : ~hs_s;
		lead      = hsn & ~s_q.hsn_prev;
		coast_ext = s_q.ctrl[hsc_pkg::COAST_POL_BIT] ? coast_s
		          : ~coast_s;                              // RL10
		coast_lim = {1'b0, s_q.period} + {1'b0, hsc_pkg::COAST_MARGIN};
		// a missing pulse past the learned period starts internal coast
		coast_int = s_q.ctrl[hsc_pkg::INT_COAST_BIT] & s_q.period_ok
		          & ({1'b0, s_q.line_cnt} > coast_lim);    // RL8
		coast_act = coast_ext | coast_int;                 // RL8
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		s_d          = s_q;
		s_d.hs_prev  = hs_s;
		s_d.hsn_prev = hsn;

		// register writes
		if (reg_wr) begin
			case (reg_addr)
				hsc_pkg::REG_OUT_CTRL: s_d.ctrl  = reg_wdata;  // RL4
				hsc_pkg::REG_PULSE_W:  s_d.width = reg_wdata;  // RL6
				hsc_pkg::REG_PHASE:
					s_d.phase = reg_wdata[hsc_pkg::PHASE_W-1:0]; // RL1
				default: ;
			endcase
		end

		// register reads, unmapped offsets answer zero
		if (reg_rd) begin
			case (reg_addr)
				hsc_pkg::REG_OUT_CTRL: s_d.rdata = s_q.ctrl;
				hsc_pkg::REG_PULSE_W:  s_d.rdata = s_q.width;
				hsc_pkg::REG_PHASE:
					s_d.rdata = {{(8-hsc_pkg::PHASE_W){1'b0}}, s_q.phase};
				hsc_pkg::REG_STATUS: begin
					s_d.rdata = '0;
					s_d.rdata[hsc_pkg::ST_POL_BIT]   = pol_high;
					s_d.rdata[hsc_pkg::ST_COAST_BIT] = s_q.hold;
				end
				default: s_d.rdata = '0;
			endcase
		end

		// run lengths of raw high and low; the shorter one is the pulse
		// each run clears where it starts, so both stand at a rise
		if (hs_s & ~s_q.hs_prev) begin
			s_d.det_pol = (s_q.hi_cnt < s_q.lo_cnt);       // RL3
			s_d.hi_cnt  = '0;
		end else if (~hs_s & s_q.hs_prev) begin
			s_d.lo_cnt  = '0;
		end else if (hs_s) begin
			if (s_q.hi_cnt != '1) s_d.hi_cnt = CW'(s_q.hi_cnt + 1'b1);
		end else begin
			if (s_q.lo_cnt != '1) s_d.lo_cnt = CW'(s_q.lo_cnt + 1'b1);
		end

		// line period, learned only from edges seen outside coast
		if (lead) begin
			s_d.line_cnt = '0;
			if (!coast_act) begin
				s_d.period    = s_q.line_cnt;
				s_d.period_ok = 1'b1;
			end
		end else if (s_q.line_cnt != '1) begin
			s_d.line_cnt = CW'(s_q.line_cnt + 1'b1);
		end

		// reference to the clock generator, gated while coasting
		s_d.ref_out = coast_act ? 1'b0 : hsn;              // RL2 RL7
		s_d.hold    = coast_act;                           // RL7

		// leading edge travels with its pixel to keep them aligned
		s_d.lead_pipe = {s_q.lead_pipe[DATA_LAT-2:0], lead};     // RL5
		s_d.pix_pipe  = {s_q.pix_pipe[DATA_LAT-2:0], pix_in};    // RL5
		s_d.pix_q     = s_q.pix_pipe[DATA_LAT-1];

		// width counter, a new edge restarts the pulse
		if (s_q.lead_pipe[DATA_LAT-1]) begin
			s_d.wcnt = s_q.width;                          // RL12
		end else if (s_q.wcnt != '0) begin
			s_d.wcnt = s_q.wcnt - 8'h01;                   // RL6
		end
		// next polarity, so a control write never leaves a stale level
		s_d.sync_out = s_d.ctrl[hsc_pkg::OUT_POL_BIT]
		             ? (s_d.wcnt != '0) : (s_d.wcnt == '0);  // RL4
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_q       <= '0;
			s_q.ctrl  <= hsc_pkg::CTRL_RST;
			s_q.width <= hsc_pkg::PULSE_W_RST;
			s_q.phase <= hsc_pkg::PHASE_RST[hsc_pkg::PHASE_W-1:0];
			// level the normalised sync shows after reset, no false edge
			s_q.hsn_prev <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs, all from flip-flops
	assign reg_rdata           = s_q.rdata;
	assign pix_out             = s_q.pix_q;
	assign pll_ref_out         = s_q.ref_out;
	assign pll_hold            = s_q.hold;
	assign sample_phase        = s_q.phase;
	assign regen_line_sync_out = s_q.sync_out;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// helper: length of the last active output run
	logic [7:0] run_len;
	logic [7:0] run_w;
	logic       act_now;
	assign act_now = (s_q.wcnt != '0);
	// a restart clears the run and takes the width loaded with it
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			run_len <= '0;
			run_w   <= '0;
		end else if (s_q.lead_pipe[DATA_LAT-1]) begin
			run_len <= '0;
			run_w   <= s_q.width;
		end else begin
			run_len <= act_now ? 8'(run_len + 1'b1) : '0;
		end
	end

	phase_write_a: assert property (                         // RL1
		reg_wr && reg_addr == hsc_pkg::REG_PHASE
		|=> sample_phase == $past(reg_wdata[hsc_pkg::PHASE_W-1:0]))
		else $error("sample phase not loaded");
	ref_follow_a: assert property (                          // RL2
		!coast_act |=> pll_ref_out == $past(hsn))
		else $error("reference does not follow sync");
	ref_block_a: assert property (                           // RL7
		coast_act |=> !pll_ref_out && pll_hold)
		else $error("reference not blocked in coast");
	pol_detect_a: assert property (                          // RL3
		hs_s && !s_q.hs_prev && s_q.hi_cnt < s_q.lo_cnt
		&& s_q.ctrl[hsc_pkg::AUTO_POL_BIT] && !reg_wr
		|=> pol_high)
		else $error("short high pulse not seen as high");
	pol_low_a: assert property (                             // RL3
		hs_s && !s_q.hs_prev && s_q.hi_cnt >= s_q.lo_cnt
		&& s_q.ctrl[hsc_pkg::AUTO_POL_BIT] && !reg_wr
		|=> !pol_high)
		else $error("short low pulse not seen as low");
	out_level_a: assert property (                           // RL4
		regen_line_sync_out
		== (s_q.ctrl[hsc_pkg::OUT_POL_BIT] ? act_now : !act_now))
		else $error("output polarity wrong");
	align_start_a: assert property (                         // RL5
		s_q.lead_pipe[DATA_LAT-1] && s_q.width != '0
		|=> act_now && pix_out == $past(s_q.pix_pipe[DATA_LAT-1]))
		else $error("sync start not with its pixel");
	width_run_a: assert property (                           // RL6
		$fell(act_now) |-> run_len == run_w)
		else $error("pulse width differs from count");
	coast_pin_a: assert property (                           // RL10
		coast_s == s_q.ctrl[hsc_pkg::COAST_POL_BIT] |=> pll_hold)
		else $error("coast pin level ignored");
	internal_coast_a: assert property (                      // RL8
		coast_int |=> !pll_ref_out ##0 pll_hold)
		else $error("internal coast not applied");
endmodule // hsc_line_sync

//--- hsc_pkg.sv
// constants shared by the line sync processing block
package hsc_pkg;
	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_OUT_CTRL  = 8'h04;
	localparam logic [7:0] REG_PHASE     = 8'h05;
	localparam logic [7:0] REG_STATUS    = 8'h06;
	localparam logic [7:0] REG_PULSE_W   = 8'h07;

	// ------------------------------------------------------------
	// field positions of the output control register
	// ------------------------------------------------------------
	localparam int OUT_POL_BIT   = 4;  // 1: output sync active high
	localparam int HS_POL_BIT    = 3;  // manual input polarity, 1: high
	localparam int AUTO_POL_BIT  = 2;  // 1: detect input polarity
	localparam int COAST_POL_BIT = 1;  // 1: coast input active high
	localparam int INT_COAST_BIT = 0;  // 1: internal coast allowed

	// status register fields
	localparam int ST_POL_BIT    = 0;  // polarity in use, 1: high
	localparam int ST_COAST_BIT  = 1;  // coast currently active

	// ------------------------------------------------------------
	// reset values and widths
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_RST    = 8'h15;
	localparam logic [7:0] PULSE_W_RST = 8'h20;
	localparam logic [7:0] PHASE_RST   = 8'h00;
	localparam int         PHASE_W     = 5;    // 32 steps per period
	localparam int         PHASE_STEPS = 32;
	localparam int         CNT_W       = 16;
	localparam logic [15:0] COAST_MARGIN = 16'h0010;
endpackage

//--- hsc_sync2.sv
// two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module hsc_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_sys,
	input  wire logic         resetn,
	// asynchronous in, synchronous out
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} hsc_sync_st_t;

	hsc_sync_st_t s_q;
	hsc_sync_st_t s_d;

	// first stage feeds only the second
	always_comb begin
		s_d        = s_q;
		s_d.meta   = d;
		s_d.stable = s_q.meta;
	end

	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign q = s_q.stable;
endmodule // hsc_sync2

//--- hsc_src_model.sv
// graphics source model: line sync, coast pin and pixel stream
`timescale 1ns/1ns
module hsc_src_model (
	// clock
	input  wire logic   clk_sys,
	// bench controls
	input  wire logic   run,
	input  wire logic   sync_high,
	input  wire logic   coast_req,
	input  wire logic   coast_high,
	// pins toward the block, and a line start flag for the bench
	output logic        line_sync_in,
	output logic        coast_in,
	output logic [23:0] pix_in,
	output logic        lead
);
	logic [7:0]  pos_q   = 8'h00;
	logic        sync_q  = 1'b0;
	logic        coast_q = 1'b1;
	logic [23:0] pix_q   = 24'h00_0000;
	logic        lead_q  = 1'b0;
	logic        act;
	// line of 40 cycles with a 6 cycle pulse while running
	assign act = run && pos_q < 8'h06;
	// pins move just after the edge; pixels count so alignment shows
	always @(posedge clk_sys) begin
		pos_q   <= (pos_q == 8'h27) ? 8'h00 : pos_q + 8'h01;
		pix_q   <= pix_q + 24'h00_0001;
		lead_q  <= run && pos_q == 8'h00;
		sync_q  <= sync_high ? act : !act;
		// sync has its own wire, so coast only on request
		coast_q <= coast_high ? coast_req : !coast_req;
	end
	// one driver per pin
	assign line_sync_in = sync_q;
	assign coast_in     = coast_q;
	assign pix_in       = pix_q;
	assign lead         = lead_q;
endmodule // hsc_src_model

//--- hsc_line_sync_test.sv
// self-checking bench for the line sync processing block
`timescale 1ns/1ns
module hsc_line_sync_test;
	logic        clk_sys = 1'b0;
	logic        resetn = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        line_sync_in, coast_in, lead, pll_ref_out, pll_hold, regen;
	logic [23:0] pix_in, pix_out;
	logic [4:0]  sample_phase;
	logic        run = 1'b0, sync_high = 1'b1;
	logic        coast_req = 1'b0, coast_high = 1'b0;
	int          errors = 0;
	int          comparisons = 0;

	hsc_line_sync hsc_line_sync_inst (.clk_sys(clk_sys), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_sync_in(line_sync_in),
		.coast_in(coast_in), .pix_in(pix_in), .pix_out(pix_out),
		.pll_ref_out(pll_ref_out), .pll_hold(pll_hold),
		.sample_phase(sample_phase), .regen_line_sync_out(regen));
	hsc_src_model hsc_src_model_inst (.clk_sys(clk_sys), .run(run),
		.sync_high(sync_high), .coast_req(coast_req),
		.coast_high(coast_high), .line_sync_in(line_sync_in),
		.coast_in(coast_in), .pix_in(pix_in), .lead(lead));

	initial forever #10 clk_sys = ~clk_sys;

	// --------------------
	// shared tasks
	// --------------------
	task automatic chk(input string nm, input logic [23:0] e,
		input logic [23:0] s);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic final_report();
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, string nm);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 chk(nm, {16'h0000, e}, {16'h0000, reg_rdata});
	endtask
	function automatic logic pick(input int w);
		case (w)
			0: return regen;
			1: return pll_hold;
			default: return lead;
		endcase
	endfunction
	// bounded wait; a missing event ends the run at once
	task automatic await(input int w, input logic lv, input int lim);
		int n = 0;
		while (pick(w) !== lv) begin
			tick();
			n++;
			if (n > lim) begin
				errors++;
				$display("[ERR] wait %0d expected %b seen %b", w, lv, pick(w));
				final_report();
			end
		end
	endtask
	// skips any pulse in flight so a width change never splits one
	task automatic pulse(input logic act, input int w);
		int n = 0;
		tick();
		await(0, !act, 400);
		await(0, act, 400);
		while (regen === act && n < 300) begin
			tick();
			n++;
		end
		chk("width", 24'(w), 24'(n));
	endtask

	// --------------------
	// scenarios
	// --------------------
	task automatic s_regs();
		rd(hsc_pkg::REG_OUT_CTRL, hsc_pkg::CTRL_RST, "ctrl");
		rd(hsc_pkg::REG_PULSE_W, hsc_pkg::PULSE_W_RST, "wid");
		rd(hsc_pkg::REG_PHASE, hsc_pkg::PHASE_RST, "phase");
		wr(hsc_pkg::REG_PHASE, 8'hFF);
		rd(hsc_pkg::REG_PHASE, 8'h1F, "phase");
		chk("sample_phase", 24'h00_001F, 24'(sample_phase));
		wr(8'h09, 8'hA5);
		rd(8'h09, 8'h00, "unmapped");
	endtask
	task automatic s_align();
		logic [23:0] stamp;
		int n = 0;
		await(2, 1'b1, 100);
		stamp = pix_in + 24'h00_0002;
		while (pll_ref_out !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		chk("ref delay", 24'h00_0003, 24'(n));
		while (regen !== 1'b1 && n < 20) begin
			tick();
			n++;
		end
		chk("sync delay", 24'h00_0006, 24'(n));
		chk("pix_out", stamp, pix_out);
	endtask
	task automatic s_coast();
		int n = 0;
		@(posedge clk_sys);
		coast_req <= 1'b1;
		await(1, 1'b1, 6);
		repeat (100) begin
			tick();
			if (pll_ref_out !== 1'b0)
				n++;
		end
		chk("ref in coast", 24'h00_0000, 24'(n));
		rd(hsc_pkg::REG_STATUS, 8'h03, "status");
		@(posedge clk_sys);
		coast_req <= 1'b0;
		await(1, 1'b0, 6);
		@(posedge clk_sys);
		coast_high <= 1'b1;
		wr(hsc_pkg::REG_OUT_CTRL, 8'h17);
		repeat (2) tick();
		chk("hold idle", 24'h00_0000, 24'(pll_hold));
		@(posedge clk_sys);
		coast_req <= 1'b1;
		await(1, 1'b1, 6);
		@(posedge clk_sys);
		coast_req <= 1'b0;
		coast_high <= 1'b0;
		wr(hsc_pkg::REG_OUT_CTRL, 8'h15);
		await(1, 1'b0, 6);
	endtask
	task automatic s_pulse();
		wr(hsc_pkg::REG_PULSE_W, 8'h04);
		pulse(1'b1, 4);
		wr(hsc_pkg::REG_OUT_CTRL, 8'h05);
		pulse(1'b0, 4);
		wr(hsc_pkg::REG_PULSE_W, 8'h01);
		pulse(1'b0, 1);
		@(posedge clk_sys);
		sync_high <= 1'b0;
		repeat (400) @(posedge clk_sys);
		pulse(1'b0, 1);
		rd(hsc_pkg::REG_STATUS, 8'h00, "auto pol");
		wr(hsc_pkg::REG_OUT_CTRL, 8'h09);
		rd(hsc_pkg::REG_STATUS, 8'h01, "manual pol");
		wr(hsc_pkg::REG_OUT_CTRL, 8'h05);
	endtask
	// sync vanishes: internal coast only while its enable bit is set
	task automatic s_internal();
		@(posedge clk_sys);
		run <= 1'b0;
		await(1, 1'b1, 120);
		@(posedge clk_sys);
		run <= 1'b1;
		repeat (200) @(posedge clk_sys);
		wr(hsc_pkg::REG_OUT_CTRL, 8'h14);
		@(posedge clk_sys);
		run <= 1'b0;
		repeat (150) @(posedge clk_sys);
		#1 chk("no coast", 24'h00_0000, 24'(pll_hold));
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge clk_sys);
		resetn <= 1'b1;
		run <= 1'b1;
		repeat (400) @(posedge clk_sys);
		s_regs();
		s_align();
		s_coast();
		s_pulse();
		s_internal();
		final_report();
	end
endmodule // hsc_line_sync_test
